//--- rtl/nsr_pkg.sv
// package: constants, register map and cycle timing of the nand status/id/reset controller
//==============================================================================
// Contract
// RULE_01: in cache programming status bit 5 shows true program readiness and bit 6 cache readiness, 0 busy and 1 ready.
// RULE_02: status bits 2 to 4 read 0, the upper byte of a wide part is don't-care, and the host masks unused bits.
// RULE_03: identification is command 90h, one address cycle 00h, then four reads: maker, device, third and fourth byte.
// RULE_04: the device stays in identification mode until another command is written.
// RULE_05: command FFh resets the device and aborts a busy random read, program or erase.
// RULE_06: cells whose program or erase was aborted by reset hold invalid data.
// RULE_07: reset clears the command register and sets status to C0h while write protect is high.
// RULE_08: after the reset command the busy output goes low for the reset busy interval, then is released.
// RULE_09: after power-up with the auto-read strap high first-page data is ready, with it low a 00h read is latched.
// RULE_10: a 3.3 V part with the strap high reads the first page at power-on with no command or address.
// RULE_11: busy is normally high, goes low on program, erase or random read start, and returns high when done.
// RULE_12: the busy output is open-drain so several devices can be wired together.
// RULE_13: after power is valid the host waits at least 10 us before any command sequence.
// RULE_14: the host keeps write protect low during power-up and power-down; the code holds it low in the power-up wait but has no power-down handling.
// RULE_15: program and erase need a setup command and a confirm command before anything starts.
// RULE_16: in cache programming bit 1 gives the previous page result at cache ready, bit 0 the current at true ready.
// RULE_17: after command 70h the device stays in status mode and every read strobe returns current status.
package nsr_pkg;
   //==========================================================================
   // clock and timing
   localparam int CLK_NS = 40;
   localparam int PWR_NS = 10000;
   localparam int WE_LOW_NS = 60;
   localparam int WE_HIGH_NS = 20;
   localparam int RE_LOW_NS = 60;
   localparam int RE_HIGH_NS = 20;
   localparam int WB_NS = 100;
   localparam int SYNC_CYC = 2;
   localparam int PWR_CYC = (PWR_NS + CLK_NS - 1) / CLK_NS;
   localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int RE_LOW_CYC = (RE_LOW_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
   localparam int RE_HIGH_CYC = (RE_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int WB_CYC = (WB_NS + CLK_NS - 1) / CLK_NS;
   //==========================================================================
   // register offsets (byte addresses)
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_STAT = 5'h04;
   localparam logic [4:0] OFS_ID = 5'h08;
   localparam logic [4:0] OFS_NSTAT = 5'h0c;
   // control fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_OP_LO = 1;
   localparam int CTRL_WPREL = 4;
   // status fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_PWROK = 1;
   localparam int STAT_READY = 2;
   localparam int STAT_DONE = 3;
   localparam int STAT_ERR = 4;
   //==========================================================================
   // device commands and status mask
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_RESET = 8'hff;
   localparam logic [7:0] ID_ADDR = 8'h00;
   localparam logic [7:0] STATUS_MASK = 8'he3;
   localparam logic [7:0] NSTAT_RESET = 8'hc0;
   localparam int ID_BYTES = 4;
   //==========================================================================
   // operations and pin cycle kinds
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_ID = 3'b001,
      OP_STATUS = 3'b010,
      OP_RESET = 3'b011,
      OP_POLL = 3'b100
   } nsr_op_e;
   typedef enum logic [1:0] {
      CYC_CMD = 2'b00,
      CYC_ADDR = 2'b01,
      CYC_READ = 2'b10
   } nsr_cyc_e;
endpackage

//--- rtl/nsr_cyc_if.sv
// interface: one pin cycle request from the sequencer to the strobe engine
`timescale 1ns/100ps
interface nsr_cyc_if;
   import nsr_pkg::*;
   logic req;
   nsr_cyc_e kind;
   logic [7:0] wdata;
   logic hold;
   logic ack;
   logic [7:0] rdata;
   modport ctl (output req, kind, wdata, hold, input ack, rdata);
   modport pin (input req, kind, wdata, hold, output ack, rdata);
endinterface

//--- rtl/nsr_strobe.sv
// strobe engine: turns one cycle request into cle/ale/we/re pin timing
`timescale 1ns/100ps
module nsr_strobe (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // request side
   nsr_cyc_if.pin c,
   // device pins
   output logic nand_ce_n,
   output logic nand_cle,
   output logic nand_ale,
   output logic nand_we_n,
   output logic nand_re_n,
   output logic [7:0] nand_io_o,
   output logic nand_io_oe,
   input wire logic [7:0] nand_io_i
);
   import nsr_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SET = 2'b01,
      ST_LOW = 2'b10,
      ST_HIGH = 2'b11
   } nsr_st_e;

   nsr_st_e st;
   logic [2:0] cnt;
   logic rd;
   logic [7:0] io_s1;
   logic [7:0] io_s2;

   //==========================================================================
   // data pins synchronised before sampling
   always_ff @(posedge aclk) begin
      io_s1 <= nand_io_i;
      io_s2 <= io_s1;
   end

   //==========================================================================
   // chip enable low across a whole sequence
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nand_ce_n <= 1'b1;
      end else begin
         nand_ce_n <= !(c.hold || c.req || st != ST_IDLE);
      end
   end

   //==========================================================================
   // strobe sequencing: setup, low phase, high phase
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= ST_IDLE;
         cnt <= 3'h0;
         rd <= 1'b0;
         nand_cle <= 1'b0;
         nand_ale <= 1'b0;
         nand_we_n <= 1'b1;
         nand_re_n <= 1'b1;
         nand_io_o <= 8'h00;
         nand_io_oe <= 1'b0;
         c.ack <= 1'b0;
         c.rdata <= 8'h00;
      end else begin
         c.ack <= 1'b0;
         case (st)
            ST_IDLE: begin
               if (c.req) begin
                  rd <= (c.kind == CYC_READ);
                  nand_cle <= (c.kind == CYC_CMD);
                  nand_ale <= (c.kind == CYC_ADDR);
                  nand_io_o <= c.wdata;
                  nand_io_oe <= (c.kind != CYC_READ);
                  st <= ST_SET;
               end
            end
            ST_SET: begin
               // latch lines settle one cycle before the strobe falls
               if (rd) begin
                  nand_re_n <= 1'b0;
                  cnt <= 3'(RE_LOW_CYC - 1);
               end else begin
                  nand_we_n <= 1'b0;
                  cnt <= 3'(WE_LOW_CYC - 1);
               end
               st <= ST_LOW;
            end
            ST_LOW: begin
               if (cnt == 3'h0) begin
                  nand_we_n <= 1'b1;
                  nand_re_n <= 1'b1;
                  if (rd) begin
                     c.rdata <= io_s2;
                     cnt <= 3'(RE_HIGH_CYC - 1);
                  end else begin
                     cnt <= 3'(WE_HIGH_CYC - 1);
                  end
                  st <= ST_HIGH;
               end else begin
                  cnt <= cnt - 3'h1;
               end
            end
            ST_HIGH: begin
               if (cnt == 3'h0) begin
                  nand_cle <= 1'b0;
                  nand_ale <= 1'b0;
                  nand_io_oe <= 1'b0;
                  c.ack <= 1'b1;
                  st <= ST_IDLE;
               end else begin
                  cnt <= cnt - 3'h1;
               end
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   //==========================================================================
   // strobe checks
   sequence we_pulse_s;
      !nand_we_n [*2] ##1 nand_we_n;
   endsequence
   sequence re_pulse_s;
      !nand_re_n [*4] ##1 nand_re_n;
   endsequence
   we_width_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_15]
      $fell(nand_we_n) |-> we_pulse_s ##1 c.ack) else $error("write strobe width wrong");
   re_width_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_17]
      $fell(nand_re_n) |-> re_pulse_s ##1 c.ack) else $error("read strobe width wrong");
   latch_setup_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
      $fell(nand_we_n) |-> $past(nand_cle || nand_ale) && nand_io_oe && !nand_ce_n)
      else $error("latch line not set up before write strobe");
   read_float_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_17]
      !nand_re_n |-> !nand_io_oe && !nand_ce_n) else $error("bus driven during read");
endmodule

//--- rtl/nsr_host.sv
// top: axi4-lite controlled host for nand status, identification and reset
`timescale 1ns/100ps
module nsr_host #(
   parameter int PWR_CYCLES = nsr_pkg::PWR_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // device pins
   output logic nand_ce_n,
   output logic nand_cle,
   output logic nand_ale,
   output logic nand_we_n,
   output logic nand_re_n,
   output logic nand_wp_n,
   output logic [7:0] nand_io_o,
   output logic nand_io_oe,
   input wire logic [7:0] nand_io_i,
   input wire logic nand_ready
);
   import nsr_pkg::*;

   // refuse a power wait that the 9-bit counter cannot hold
   if (PWR_CYCLES < 1 || PWR_CYCLES > 511) begin : g_pwr_check
      $error("PWR_CYCLES out of range 1..511");
   end

   typedef enum logic [2:0] {
      M_PWR = 3'b000,
      M_IDLE = 3'b001,
      M_CMD = 3'b010,
      M_ADR = 3'b011,
      M_RD = 3'b100,
      M_WB = 3'b101,
      M_RB = 3'b110
   } nsr_state_e;

   nsr_cyc_if c ();

   nsr_state_e state;
   nsr_op_e op;
   nsr_op_e cur_op;
   logic [8:0] pwr_cnt;
   logic [2:0] wb_cnt;
   logic [1:0] rd_idx;
   logic pend;
   logic go;
   logic wp_rel;
   logic done;
   logic err;
   logic rdy_s1;
   logic rdy_s2;
   logic [7:0] id_byte [ID_BYTES];
   logic [7:0] nstat;
   logic [4:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_do;
   logic [31:0] rd_mux;
   logic [1:0] rd_resp;

   //==========================================================================
   // pin cycle engine
   nsr_strobe u_strobe (
      .aclk(aclk),
      .aresetn(aresetn),
      .c(c.pin),
      .nand_ce_n(nand_ce_n),
      .nand_cle(nand_cle),
      .nand_ale(nand_ale),
      .nand_we_n(nand_we_n),
      .nand_re_n(nand_re_n),
      .nand_io_o(nand_io_o),
      .nand_io_oe(nand_io_oe),
      .nand_io_i(nand_io_i)
   );

   //==========================================================================
   // open-drain busy line synchronised
   always_ff @(posedge aclk) begin
      rdy_s1 <= nand_ready; // [RULE_12]
      rdy_s2 <= rdy_s1;
   end

   //==========================================================================
   // axi write channels: address and data taken in either order
   assign wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         aw_addr <= 5'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[4] == 1'b0) ? 2'b00 : 2'b10;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   //==========================================================================
   // control register: operation select, write-protect release, go pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op <= OP_NONE;
         wp_rel <= 1'b0;
         go <= 1'b0;
      end else begin
         go <= 1'b0;
         if (wr_do && aw_addr == OFS_CTRL && w_strb[0]) begin
            op <= nsr_op_e'(w_data[CTRL_OP_LO +: 3]);
            wp_rel <= w_data[CTRL_WPREL];
            go <= w_data[CTRL_GO];
         end
      end
   end

   //==========================================================================
   // write protect held low until power settles and software releases it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nand_wp_n <= 1'b0;
      end else begin
         nand_wp_n <= wp_rel && state != M_PWR; // [RULE_14]
      end
   end

   //==========================================================================
   // axi read channel
   always_comb begin
      rd_mux = 32'h0;
      rd_resp = 2'b00;
      case (s_axi_araddr[4:2])
         3'h0: rd_mux = {27'h0, wp_rel, op, 1'b0};
         3'h1: rd_mux = {27'h0, err, done, rdy_s2, state != M_PWR, state > M_IDLE};
         3'h2: rd_mux = {id_byte[3], id_byte[2], id_byte[1], id_byte[0]};
         3'h3: rd_mux = {24'h0, nstat};
         default: rd_resp = 2'b10;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_resp;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   //==========================================================================
   // operation sequencer
   assign c.hold = state == M_CMD || state == M_ADR || state == M_RD;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= M_PWR;
         cur_op <= OP_NONE;
         pwr_cnt <= 9'h0;
         wb_cnt <= 3'h0;
         rd_idx <= 2'h0;
         pend <= 1'b0;
         c.req <= 1'b0;
         c.kind <= CYC_CMD;
         c.wdata <= 8'h00;
         done <= 1'b0;
         err <= 1'b0;
      end else begin
         c.req <= 1'b0;
         if (c.ack) begin
            pend <= 1'b0;
         end
         case (state)
            M_PWR: begin
               // no command until the recovery time has run
               if (pwr_cnt == 9'(PWR_CYCLES - 1)) begin // [RULE_13]
                  state <= M_IDLE;
               end else begin
                  pwr_cnt <= pwr_cnt + 9'h1;
               end
            end
            M_IDLE: begin
               if (go) begin
                  cur_op <= op;
                  rd_idx <= 2'h0;
                  done <= 1'b0;
                  err <= 1'b0;
                  // only non-altering commands are sent, so no setup/confirm pair arises
                  case (op)
                     OP_ID: begin // [RULE_03]
                        c.wdata <= CMD_READ_ID;
                        state <= M_CMD;
                     end
                     OP_STATUS: begin // [RULE_17]
                        c.wdata <= CMD_STATUS;
                        state <= M_CMD;
                     end
                     OP_RESET: begin // [RULE_15]
                        c.wdata <= CMD_RESET;
                        state <= M_CMD;
                     end
                     OP_POLL: begin // [RULE_04]
                        state <= M_RD;
                     end
                     default: begin
                        err <= 1'b1;
                     end
                  endcase
               end
            end
            M_CMD: begin
               if (!pend) begin
                  c.req <= 1'b1;
                  c.kind <= CYC_CMD;
                  pend <= 1'b1;
               end else if (c.ack) begin
                  case (cur_op)
                     OP_ID: begin
                        c.wdata <= ID_ADDR; // [RULE_03]
                        state <= M_ADR;
                     end
                     OP_RESET: begin
                        wb_cnt <= 3'(WB_CYC - 1);
                        state <= M_WB;
                     end
                     default: begin
                        state <= M_RD;
                     end
                  endcase
               end
            end
            M_ADR: begin
               if (!pend) begin
                  c.req <= 1'b1;
                  c.kind <= CYC_ADDR;
                  pend <= 1'b1;
               end else if (c.ack) begin
                  state <= M_RD;
               end
            end
            M_RD: begin
               if (!pend) begin
                  c.req <= 1'b1;
                  c.kind <= CYC_READ;
                  pend <= 1'b1;
               end else if (c.ack) begin
                  rd_idx <= rd_idx + 2'h1;
                  if (cur_op != OP_ID || rd_idx == 2'(ID_BYTES - 1)) begin
                     done <= 1'b1;
                     state <= M_IDLE;
                  end
               end
            end
            M_WB: begin
               // let the device pull busy low before watching it
               if (wb_cnt == 3'h0) begin
                  state <= M_RB;
               end else begin
                  wb_cnt <= wb_cnt - 3'h1;
               end
            end
            M_RB: begin
               if (rdy_s2) begin // [RULE_08]
                  done <= 1'b1;
                  state <= M_IDLE;
               end
            end
            default: begin
               state <= M_IDLE;
            end
         endcase
         if (go && state != M_IDLE) begin
            err <= 1'b1;
         end
      end
   end

   //==========================================================================
   // read data capture: id bytes in order, status masked
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nstat <= NSTAT_RESET;
         for (int i = 0; i < ID_BYTES; i++) begin
            id_byte[i] <= 8'h00;
         end
      end else if (state == M_RD && c.ack) begin
         if (cur_op == OP_ID) begin
            id_byte[rd_idx] <= c.rdata; // [RULE_03]
         end else begin
            nstat <= c.rdata & STATUS_MASK; // [RULE_02]
         end
      end
   end

   //==========================================================================
   // sequence checks
   wp_powerup_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_14]
      state == M_PWR |=> !nand_wp_n) else $error("write protect released in power-up");
   no_cmd_pwr_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_13]
      state == M_PWR |-> !c.req && nand_ce_n) else $error("command during power-up wait");
   id_addr_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
      state == M_CMD && c.ack && cur_op == OP_ID |=> state == M_ADR && c.wdata == ID_ADDR)
      else $error("id command not followed by address 00");
   reset_wait_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_08]
      $rose(state == M_WB) |-> (state == M_WB) [*3] ##1 state == M_RB)
      else $error("reset busy wait too short");
   reset_cmd_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_05]
      state == M_WB |-> cur_op == OP_RESET && $past(c.wdata) == CMD_RESET)
      else $error("busy wait without reset command");
   bresp_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
      else $error("write response before both channels taken");
endmodule

//--- dv/nsr_dev_model.sv
// device model: status, id and reset side of the flash part
`timescale 1ns/100ps
module nsr_dev_model #(
   parameter logic [7:0] MAKER = 8'h3c, // arbitrary
   parameter int RST_NS = 400
) (
   // strobes
   input wire logic ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic re_n,
   input wire logic wp_n,
   // bus and busy pull-down
   input wire logic [7:0] io_in,
   output logic [7:0] io_out,
   output logic rb_pull
);
   logic [7:0] mode = 8'h00; // read latched at power-up
   logic [7:0] stat = 8'hc0;
   logic [7:0] last = 8'h00;
   logic [7:0] cur;
   logic [1:0] idx = 2'h0;
   logic [7:0] id [4] = '{MAKER, 8'h5a, 8'h11, 8'h22}; // arbitrary id bytes
   initial rb_pull = 1'b0;
   // command and address latch on write strobe rise
   always @(posedge we_n) begin
      if (!ce_n && cle) mode <= io_in; // kept until next command
      if (!ce_n && cle && io_in == 8'hff) begin
         stat <= wp_n ? 8'hc0 : 8'h40;
         rb_pull <= 1'b1;
         #(RST_NS);
         rb_pull <= 1'b0;
      end
   end
   // status or id byte in current mode
   assign cur = (mode == 8'h70) ? stat : (mode == 8'h90) ? id[idx] : 8'h00;
   // released bus shows inverse of last byte
   assign io_out = (!ce_n && !re_n) ? cur : ~last;
   // id pointer cleared by a latch cycle, stepped by each read
   always @(posedge we_n or posedge re_n) begin
      if (!ce_n && (cle || ale)) begin
         idx <= 2'h0;
      end else if (!ce_n) begin
         last <= cur;
         idx <= idx + 2'h1;
      end
   end
endmodule

//--- dv/nsr_host_tb_top.sv
// testbench: controller registers against the device model
`timescale 1ns/100ps
module nsr_host_tb_top;
   import nsr_pkg::*;
   localparam logic [7:0] MAKER = 8'h3c; // arbitrary
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [4:0] awaddr = 5'h00;
   logic [4:0] araddr = 5'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, rd;
   logic awready, wready, bvalid, arready, rvalid, ce_n, cle, ale, we_n, re_n, wp_n, oe, pull;
   logic [1:0] bresp, rresp, rs, bs;
   logic [7:0] io_o, dev_o;
   wire logic [7:0] io_bus = oe ? io_o : dev_o;
   wire logic rdy = ~pull; // open-drain line with pull-up
   int num_errors = 0, samples_checked = 0, cyc = 0, low_cyc = 0;
   always #20 aclk = ~aclk;
   nsr_host #(.PWR_CYCLES(20)) i_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n),
      .nand_wp_n(wp_n), .nand_io_o(io_o), .nand_io_oe(oe), .nand_io_i(io_bus),
      .nand_ready(rdy));
   nsr_dev_model #(.MAKER(MAKER)) i_dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
      .re_n(re_n), .wp_n(wp_n), .io_in(io_bus), .io_out(dev_o), .rb_pull(pull));
   //==========================================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [4:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // start one device operation and wait for done
   task automatic op(input logic [2:0] o, input logic w);
      wr(OFS_CTRL, {27'h0, w, o, 1'b1});
      rd = 32'h0;
      for (int i = 0; i < 400 && !rd[STAT_DONE]; i++) rdr(OFS_STAT);
      chk(rd[STAT_ERR:STAT_DONE], 2'b01);
   endtask
   //==========================================================================
   // scenarios
   task automatic t_power();
      chk(wp_n, 1'b0);
      wr(OFS_CTRL, 32'h3); // go during power wait
      chk(bs, 2'b00);
      rdr(OFS_STAT);
      chk(rd[STAT_ERR], 1'b1);
      rdr(OFS_NSTAT);
      chk(rd, 32'hc0);
      rdr(5'h10);
      chk(rs, 2'b10);
      wr(5'h10, 32'h0);
      chk(bs, 2'b10);
      for (int i = 0; i < 100 && !rd[STAT_PWROK]; i++) rdr(OFS_STAT);
   endtask
   task automatic t_id();
      op(3'h1, 1'b0);
      rdr(OFS_ID);
      chk(rd, {8'h22, 8'h11, 8'h5a, MAKER});
      op(3'h4, 1'b0);
      rdr(OFS_NSTAT);
      chk(rd, MAKER & STATUS_MASK);
      wr(OFS_CTRL, 32'hb); // unknown op 5 is refused
      rdr(OFS_STAT);
      chk(rd[STAT_ERR], 1'b1);
   endtask
   task automatic t_status();
      op(3'h2, 1'b1);
      chk(wp_n, 1'b1);
      rdr(OFS_NSTAT);
      chk(rd, 32'hc0);
      op(3'h4, 1'b1);
      rdr(OFS_NSTAT);
      chk(rd, 32'hc0);
   endtask
   task automatic t_reset(input logic w, input logic [7:0] exp);
      low_cyc = 0;
      op(3'h3, w);
      chk(low_cyc inside {[9:11]}, 1'b1);
      chk(rd[STAT_READY], 1'b1);
      op(3'h2, w);
      rdr(OFS_NSTAT);
      chk(rd, exp);
   endtask
   task automatic report_and_stop();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // cycle count, busy length and timeout
   always @(posedge aclk) begin
      cyc++;
      if (!rdy) low_cyc++;
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_power();
      t_id();
      t_status();
      t_reset(1'b1, 8'hc0);
      t_reset(1'b0, 8'h40);
      report_and_stop();
   end
endmodule
